// ### design/qdw_defines.vh
// constants, register map and field layout for the queued write command block
`ifndef QDW_DEFINES_VH
`define QDW_DEFINES_VH
`define QDW_A_ERR       8'h00
`define QDW_A_FEAT      8'h04
`define QDW_A_COUNT     8'h08
`define QDW_A_SECT      8'h0c
`define QDW_A_TLOW      8'h10
`define QDW_A_THIGH     8'h14
`define QDW_A_DHEAD     8'h18
`define QDW_A_STAT      8'h1c
`define QDW_A_CMD       8'h1c
`define QDW_A_CTRL      8'h20
`define QDW_A_MEDIA     8'h24
`define QDW_A_XFER      8'h28
`define QDW_A_ADDR      8'h2c
`define QDW_A_EVT       8'h30
`define QDW_OP_QWRITE   8'hcc
`define QDW_OP_WMULT    8'hc5
`define QDW_OP_SERVICE  8'ha2
`define QDW_OP_MSTAT    8'hda
`define QDW_LBA_BIT     6
`define QDW_TAG_LSB     3
`define QDW_ST_BSY      7
`define QDW_ST_DEVICE_READY     6
`define QDW_ST_DF       5
`define QDW_ST_QUEUE_ATTENTION_FLAG     4
`define QDW_ST_DRQ      3
`define QDW_ST_ERR      0
`define QDW_CT_REL      2
`define QDW_CT_IO       1
`define QDW_CT_CD       0
`define QDW_ER_INTERFACE_CRC_ERROR     7
`define QDW_ER_WP       6
`define QDW_ER_MC       5
`define QDW_ER_ADDRESS_NOT_FOUND     4
`define QDW_ER_MCR      3
`define QDW_ER_COMMAND_ABORTED     2
`define QDW_ER_NM       1
`define QDW_STAT_RST    8'h40
`define QDW_BYTE0       8'h00
`define QDW_SECT256     9'h100
`define QDW_RESP_OKAY   2'b00
`define QDW_RESP_SLVERR 2'b10
`endif

// ### design/qdw_core.v
// queued dma write command interpreter with axi4-lite register access
`timescale 1ns/10ps
`include "qdw_defines.vh"
module qdw_core #(
  parameter QUEUE_SUPPORT = 1,
  parameter REMOVABLE     = 1
) (
  // clock and reset
  input  wire        i_mclk,
  input  wire        i_resetn,
  // axi4-lite write address and data
  input  wire [7:0]  i_awaddr,
  input  wire        i_awvalid,
  output wire        o_awready,
  input  wire [31:0] i_wdata,
  input  wire [3:0]  i_wstrb,
  input  wire        i_wvalid,
  output wire        o_wready,
  // axi4-lite write response
  output reg  [1:0]  o_bresp,
  output reg         o_bvalid,
  input  wire        i_bready,
  // axi4-lite read
  input  wire [7:0]  i_araddr,
  input  wire        i_arvalid,
  output wire        o_arready,
  output reg  [31:0] o_rdata,
  output reg  [1:0]  o_rresp,
  output reg         o_rvalid,
  input  wire        i_rready,
  // data transfer engine
  output reg         o_xfer_start,
  output reg         o_pio_mode,
  output reg  [8:0]  o_xfer_sectors,
  output reg  [27:0] o_start_addr,
  output reg         o_lba_mode,
  input  wire        i_sector_done,
  input  wire        i_xfer_error,
  input  wire        i_udma_mode,
  input  wire        i_crc_error,
  // media and queue state
  input  wire        i_media_changed,
  input  wire        i_change_request,
  input  wire        i_write_protect,
  input  wire        i_no_media,
  input  wire        i_other_ready,
  input  wire        i_addr_missing,
  input  wire        i_no_translation,
  input  wire        i_out_of_range,
  input  wire        i_device_fault,
  output reg         o_queue_abort,
  output wire        o_busy
);
  localparam S_IDLE = 5'b00001;
  localparam S_DATA = 5'b00010;
  localparam S_REL  = 5'b00100;
  localparam S_DONE = 5'b01000;
  localparam S_FAIL = 5'b10000;

  reg  [4:0]  state;
  reg  [7:0]  error_report;
  reg  [7:0]  count_and_tag;
  reg  [7:0]  start_sector_low;
  reg  [7:0]  track_low_byte;
  reg  [7:0]  track_high_byte;
  reg  [7:0]  drive_and_head_select;
  reg  [7:0]  command_state;
  reg  [7:0]  feat;
  reg  [31:0] tag_valid;
  reg         ovl_irq_en;
  reg         prepared;
  reg         mc_record;
  reg         mcr_flag;
  reg  [8:0]  remain;
  reg  [27:0] cur_addr;
  reg         aw_hold;
  reg         w_hold;
  reg  [7:0]  aw_addr;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;

  wire [4:0]  tag = count_and_tag[7:`QDW_TAG_LSB];
  wire        lba = drive_and_head_select[`QDW_LBA_BIT];
  assign o_busy = command_state[`QDW_ST_BSY];

  // both halves latched independently so either may arrive first
  assign o_awready = ~aw_hold & ~o_bvalid;
  assign o_wready  = ~w_hold & ~o_bvalid;
  assign o_arready = ~o_rvalid;
  wire do_wr = aw_hold & w_hold;
  wire cmd_wr = do_wr & (aw_addr == `QDW_A_CMD) & w_strb[0];

  // start address from the address registers
  wire [27:0] req_addr = lba ?
    {drive_and_head_select[3:0], track_high_byte, track_low_byte, start_sector_low} :
    {drive_and_head_select[3:0], track_high_byte, track_low_byte, start_sector_low};
  wire [7:0]  tag_field = QUEUE_SUPPORT ? {tag, 3'b000} : `QDW_BYTE0;

  // error bits gathered at failure
  wire address_not_found_bit = i_addr_missing | i_no_translation | (i_out_of_range & ~i_xfer_error);
  wire command_aborted_bit = (i_udma_mode & (i_crc_error | i_xfer_error)) | (i_out_of_range & ~address_not_found_bit);
  wire [7:0] err_bits = {i_udma_mode & i_crc_error,
                         REMOVABLE ? i_write_protect : 1'b0,
                         REMOVABLE ? mc_record : 1'b0,
                         address_not_found_bit,
                         REMOVABLE ? mcr_flag : 1'b0,
                         command_aborted_bit,
                         REMOVABLE ? i_no_media : 1'b0,
                         1'b0};
  wire fail_now = i_xfer_error | (i_udma_mode & i_crc_error) | i_addr_missing |
                  i_no_translation | i_out_of_range;

  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      aw_hold <= 1'b0;
      w_hold  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      o_bvalid <= 1'b0;
      o_bresp <= `QDW_RESP_OKAY;
    end else begin
      if (i_awvalid & o_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= i_awaddr;
      end
      if (i_wvalid & o_wready) begin
        w_hold <= 1'b1;
        w_data <= i_wdata;
        w_strb <= i_wstrb;
      end
      if (do_wr) begin
        aw_hold  <= 1'b0;
        w_hold   <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp  <= (aw_addr > `QDW_A_EVT) ? `QDW_RESP_SLVERR : `QDW_RESP_OKAY;
      end else if (o_bvalid & i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rvalid <= 1'b0;
      o_rdata  <= 32'h0000_0000;
      o_rresp  <= `QDW_RESP_OKAY;
    end else if (i_arvalid & o_arready) begin
      o_rvalid <= 1'b1;
      o_rresp  <= `QDW_RESP_OKAY;
      case (i_araddr)
        `QDW_A_ERR:   o_rdata <= {24'h0, error_report};
        `QDW_A_FEAT:  o_rdata <= {24'h0, feat};
        `QDW_A_COUNT: o_rdata <= {24'h0, count_and_tag};
        `QDW_A_SECT:  o_rdata <= {24'h0, start_sector_low};
        `QDW_A_TLOW:  o_rdata <= {24'h0, track_low_byte};
        `QDW_A_THIGH: o_rdata <= {24'h0, track_high_byte};
        `QDW_A_DHEAD: o_rdata <= {24'h0, drive_and_head_select};
        `QDW_A_STAT:  o_rdata <= {24'h0, command_state};
        `QDW_A_CTRL:  o_rdata <= {31'h0, ovl_irq_en};
        `QDW_A_MEDIA: o_rdata <= {30'h0, mcr_flag, mc_record};
        `QDW_A_XFER:  o_rdata <= {23'h0, remain};
        `QDW_A_ADDR:  o_rdata <= {4'h0, cur_addr};
        `QDW_A_EVT:   o_rdata <= tag_valid;
        default: begin
          o_rdata <= 32'h0000_0000;
          o_rresp <= `QDW_RESP_SLVERR;
        end
      endcase
    end else if (o_rvalid & i_rready) begin
      o_rvalid <= 1'b0;
    end
  end

  // register writes blocked while busy; host waits for ready
  wire wr_ok = do_wr & ~o_busy;

  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= S_IDLE;
      error_report <= 8'h00;
      count_and_tag <= 8'h00;
      start_sector_low <= 8'h00;
      track_low_byte <= 8'h00;
      track_high_byte <= 8'h00;
      drive_and_head_select <= 8'h00;
      command_state <= `QDW_STAT_RST;
      feat <= 8'h00;
      tag_valid <= 32'h0000_0000;
      ovl_irq_en <= 1'b0;
      prepared <= 1'b0;
      mc_record <= 1'b0;
      mcr_flag <= 1'b0;
      remain <= 9'h000;
      cur_addr <= 28'h0000000;
      o_xfer_start <= 1'b0;
      o_pio_mode <= 1'b0;
      o_xfer_sectors <= 9'h000;
      o_start_addr <= 28'h0000000;
      o_lba_mode <= 1'b0;
      o_queue_abort <= 1'b0;
    end else begin
      o_xfer_start <= 1'b0;
      o_queue_abort <= 1'b0;
      // set wins over clear for hardware-detected media events
      if (REMOVABLE && i_media_changed)
        mc_record <= 1'b1;
      if (REMOVABLE && i_change_request)
        mcr_flag <= 1'b1;
      if (wr_ok) begin
        case (aw_addr)
          `QDW_A_FEAT:  if (w_strb[0]) feat <= w_data[7:0];
          `QDW_A_COUNT: if (w_strb[0]) count_and_tag <= w_data[7:0];
          `QDW_A_SECT:  if (w_strb[0]) start_sector_low <= w_data[7:0];
          `QDW_A_TLOW:  if (w_strb[0]) track_low_byte <= w_data[7:0];
          `QDW_A_THIGH: if (w_strb[0]) track_high_byte <= w_data[7:0];
          `QDW_A_DHEAD: if (w_strb[0]) drive_and_head_select <= w_data[7:0];
          `QDW_A_CTRL:  if (w_strb[0]) ovl_irq_en <= w_data[0];
          `QDW_A_EVT:   if (w_strb[0]) prepared <= w_data[0];
          default: ;
        endcase
      end
      case (state)
        S_IDLE: begin
          if (cmd_wr & ~o_busy) begin
            case (w_data[7:0])
              `QDW_OP_QWRITE: begin
                if (!ovl_irq_en || (QUEUE_SUPPORT && tag_valid[tag])) begin
                  error_report <= 8'h01 << `QDW_ER_COMMAND_ABORTED;
                  command_state <= (8'h01 << `QDW_ST_DEVICE_READY) | (8'h01 << `QDW_ST_ERR);
                  count_and_tag <= tag_field | (8'h01 << `QDW_CT_IO) | (8'h01 << `QDW_CT_CD);
                end else begin
                  remain <= (feat == `QDW_BYTE0) ? `QDW_SECT256 : {1'b0, feat};
                  cur_addr <= req_addr;
                  o_start_addr <= req_addr;
                  o_lba_mode <= lba;
                  o_pio_mode <= 1'b0;
                  error_report <= 8'h00;
                  if (QUEUE_SUPPORT)
                    tag_valid[tag] <= 1'b1;
                  if (prepared) begin
                    // data ready: transfer at once, no release
                    o_xfer_sectors <= (feat == `QDW_BYTE0) ? `QDW_SECT256 : {1'b0, feat};
                    o_xfer_start <= 1'b1;
                    command_state <= (8'h01 << `QDW_ST_BSY) | (8'h01 << `QDW_ST_DEVICE_READY) |
                                     (8'h01 << `QDW_ST_DRQ);
                    state <= S_DATA;
                  end else begin
                    state <= S_REL;
                  end
                end
              end
              `QDW_OP_WMULT: begin
                remain <= (count_and_tag == `QDW_BYTE0) ? `QDW_SECT256 : {1'b0, count_and_tag};
                o_xfer_sectors <= (count_and_tag == `QDW_BYTE0) ? `QDW_SECT256 :
                                  {1'b0, count_and_tag};
                cur_addr <= req_addr;
                o_start_addr <= req_addr;
                o_lba_mode <= lba;
                o_pio_mode <= 1'b1;
                o_xfer_start <= 1'b1;
                error_report <= 8'h00;
                mcr_flag <= i_change_request; // media access command clears request
                command_state <= (8'h01 << `QDW_ST_BSY) | (8'h01 << `QDW_ST_DEVICE_READY) |
                                 (8'h01 << `QDW_ST_DRQ);
                state <= S_DATA;
              end
              `QDW_OP_SERVICE: begin
                if (command_state[`QDW_ST_QUEUE_ATTENTION_FLAG] && prepared) begin
                  o_xfer_sectors <= remain;
                  o_xfer_start <= 1'b1;
                  count_and_tag <= tag_field;
                  command_state <= (8'h01 << `QDW_ST_BSY) | (8'h01 << `QDW_ST_DEVICE_READY) |
                                   (8'h01 << `QDW_ST_DRQ);
                  state <= S_DATA;
                end
              end
              `QDW_OP_MSTAT: mcr_flag <= i_change_request;
              default: begin
                error_report <= 8'h01 << `QDW_ER_COMMAND_ABORTED;
                command_state <= (8'h01 << `QDW_ST_DEVICE_READY) | (8'h01 << `QDW_ST_ERR);
              end
            endcase
          end
        end
        S_REL: begin
          count_and_tag <= tag_field | (8'h01 << `QDW_CT_REL);
          command_state <= (8'h01 << `QDW_ST_DEVICE_READY) |
                           ({7'h00, i_other_ready | prepared} << `QDW_ST_QUEUE_ATTENTION_FLAG);
          state <= S_IDLE;
        end
        S_DATA: begin
          // no release path from here until all sectors done
          if (fail_now) begin
            error_report <= err_bits;
            if (REMOVABLE)
              mc_record <= i_media_changed;
            state <= S_FAIL;
          end else if (i_sector_done) begin
            cur_addr <= cur_addr + 28'h0000001;
            remain <= remain - 9'h001;
            if (remain == 9'h001)
              state <= S_DONE;
          end
        end
        S_DONE: begin
          error_report <= 8'h00;
          count_and_tag <= tag_field | (8'h01 << `QDW_CT_IO) | (8'h01 << `QDW_CT_CD);
          command_state <= (8'h01 << `QDW_ST_DEVICE_READY) |
                           ({7'h00, i_other_ready} << `QDW_ST_QUEUE_ATTENTION_FLAG);
          if (QUEUE_SUPPORT)
            tag_valid[tag] <= 1'b0;
          prepared <= 1'b0;
          state <= S_IDLE;
        end
        S_FAIL: begin
          {drive_and_head_select[3:0], track_high_byte, track_low_byte, start_sector_low}
            <= cur_addr;
          count_and_tag <= tag_field | (8'h01 << `QDW_CT_IO) | (8'h01 << `QDW_CT_CD);
          command_state <= (8'h01 << `QDW_ST_DEVICE_READY) |
                           ({7'h00, i_device_fault} << `QDW_ST_DF) |
                           ({7'h00, |error_report} << `QDW_ST_ERR);
          tag_valid <= 32'h0000_0000;
          o_queue_abort <= 1'b1;
          prepared <= 1'b0;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule

// ### tb/qdw_core_asserts.sv
// bus handshake and command-flow checks on the queued write block
`timescale 1ns/10ps
module qdw_core_asserts (
  // clock and reset
  input wire       i_mclk,
  input wire       i_resetn,
  // register bus
  input wire [7:0] i_awaddr,
  input wire       i_awvalid,
  input wire       o_awready,
  input wire       i_wvalid,
  input wire       o_wready,
  input wire [1:0] o_bresp,
  input wire       o_bvalid,
  input wire       i_bready,
  input wire       i_arvalid,
  input wire       o_arready,
  input wire       o_rvalid,
  input wire       i_rready,
  // transfer engine
  input wire       o_xfer_start,
  input wire [8:0] o_xfer_sectors,
  input wire       i_sector_done,
  input wire       i_xfer_error,
  input wire       o_queue_abort,
  input wire       o_busy
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  // sectors still owed by the running transfer
  reg [8:0] left;
  reg       run;
  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      run  <= 1'b0;
      left <= 9'h0;
    end else if (o_xfer_start) begin
      run  <= 1'b1;
      left <= o_xfer_sectors;
    end else if (run) begin
      if (i_sector_done) left <= left - 9'h1;
      if (i_xfer_error || (i_sector_done && left == 9'h1)) run <= 1'b0;
    end
  end
  sequence wr_both;
    i_awvalid && o_awready && i_wvalid && o_wready;
  endsequence
  sequence last_sector;
    run && i_sector_done && left == 9'h1;
  endsequence
  busy_in_xfer_a: assert property (run |-> o_busy)
    else $error("busy low during data transfer");
  busy_release_a: assert property (last_sector |-> ##[1:16] !o_busy)
    else $error("busy held after last sector");
  start_pulse_a: assert property (o_xfer_start |=> !o_xfer_start)
    else $error("transfer start longer than one cycle");
  sector_range_a: assert property (o_xfer_start |-> o_xfer_sectors inside {[1:256]})
    else $error("sector count out of range");
  abort_pulse_a: assert property (o_queue_abort |=> !o_queue_abort)
    else $error("queue abort longer than one cycle");
  abort_cause_a: assert property (o_queue_abort |-> $past(run, 2))
    else $error("queue abort without a running transfer");
  bresp_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped early");
  rvalid_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid)
    else $error("read data dropped early");
  read_answer_a: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read answer late");
  bad_write_a: assert property (wr_both ##0 i_awaddr > 8'h30 |-> ##2 o_bvalid && o_bresp == 2'b10)
    else $error("unmapped write not refused");
endmodule

// ### tb/qdw_engine_model.sv
// behavioural data engine answering the block's transfer start
`timescale 1ns/10ps
module qdw_engine_model (
  // clock and reset
  input  wire       i_mclk,
  input  wire       i_resetn,
  // block side
  input  wire       i_xfer_start,
  input  wire [8:0] i_xfer_sectors,
  input  wire       i_busy,
  // scenario controls and responses to the block
  input  wire       i_slow,
  input  wire       i_fail,
  output reg        o_sector_done,
  output reg        o_xfer_error,
  output reg        o_crc_error,
  output reg        o_udma_mode
);
  integer k;
  initial begin
    {o_sector_done, o_xfer_error, o_crc_error, o_udma_mode} = 4'h0;
    forever begin
      @(posedge i_mclk);
      if (i_resetn && i_xfer_start) begin
        o_udma_mode <= 1'b1;
        if (i_fail) begin
          // checksum failure at the first sector, held until the block ends
          o_xfer_error <= 1'b1;
          o_crc_error  <= 1'b1;
          repeat (3) @(posedge i_mclk);
          while (i_busy) @(posedge i_mclk);
        end else begin
          for (k = 0; k < i_xfer_sectors; k++) begin
            repeat (i_slow ? 5 : 1) @(posedge i_mclk);
            o_sector_done <= 1'b1;
            @(posedge i_mclk);
            o_sector_done <= 1'b0;
          end
        end
        {o_xfer_error, o_crc_error, o_udma_mode} <= 3'h0;
      end
    end
  end
endmodule

// ### tb/queued_dma_write_status_bench.sv
// self-checking bench for the queued write command block
`timescale 1ns/10ps
`include "qdw_defines.vh"
module queued_dma_write_status_bench;
  reg         i_mclk = 0, i_resetn = 0;
  reg  [7:0]  awaddr = 0, araddr = 0, env = 0;
  reg  [31:0] wdata = 0;
  reg         awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  wire        awready, wready, bvalid, arready, rvalid, xstart, pio, lba, busy, qabort;
  wire        sdone, xerr, crc, udma;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire [8:0]  sectors;
  wire [27:0] addr;
  reg  [33:0] rq[$];
  reg  [38:0] xq[$];
  reg  [1:0]  bq[$];
  reg  [27:0] xa;
  reg  [7:0]  tag;
  integer     fails = 0, comparisons = 0, seed = 32'h8423, i;
  always #2 i_mclk = ~i_mclk;
  qdw_core i_qdw_core (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'h1),
    .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
    .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .o_xfer_start(xstart), .o_pio_mode(pio), .o_xfer_sectors(sectors),
    .o_start_addr(addr), .o_lba_mode(lba), .i_sector_done(sdone), .i_xfer_error(xerr),
    .i_udma_mode(udma), .i_crc_error(crc), .i_media_changed(env[4]),
    .i_change_request(env[5]), .i_write_protect(env[6]), .i_no_media(env[7]),
    .i_other_ready(env[2]), .i_addr_missing(1'b0), .i_no_translation(1'b0),
    .i_out_of_range(1'b0), .i_device_fault(env[3]), .o_queue_abort(qabort), .o_busy(busy));
  qdw_engine_model i_qdw_engine_model (.i_mclk(i_mclk), .i_resetn(i_resetn),
    .i_xfer_start(xstart), .i_xfer_sectors(sectors), .i_busy(busy), .i_slow(env[1]),
    .i_fail(env[0]), .o_sector_done(sdone), .o_xfer_error(xerr), .o_crc_error(crc),
    .o_udma_mode(udma));
  task chk(input [47:0] nm, input [38:0] e, input [38:0] s);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %0s expected %h seen %h", nm, e, s);
    end
  endtask
  always @(posedge i_mclk) if (rvalid && rready) chk("rdata", rq.pop_front(), {rresp, rdata});
  always @(posedge i_mclk) if (bvalid && bready) chk("bresp", bq.pop_front(), bresp);
  always @(posedge i_mclk) if (xstart) chk("xfer", xq.pop_front(), {pio, lba, sectors, addr});
  task automatic wr(input [7:0] a, input [31:0] d, input [1:0] r = 2'b00);
    bit ta, tw, tb;
    begin
      bq.push_back(r);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      {ta, tw, tb} = 3'h0;
      while (!(ta && tw)) begin
        @(negedge i_mclk);
        ta |= awvalid && awready;
        tw |= wvalid && wready;
        @(posedge i_mclk);
        if (ta) awvalid <= 1'b0;
        if (tw) wvalid <= 1'b0;
        bready <= ta && tw;
      end
      while (!tb) begin
        @(negedge i_mclk);
        tb = bvalid;
        @(posedge i_mclk);
      end
      bready <= 1'b0;
    end
  endtask
  task automatic rd(input [7:0] a, input [31:0] d, input [1:0] r = 2'b00);
    bit t;
    begin
      rq.push_back({r, d});
      araddr  <= a;
      arvalid <= 1'b1;
      for (t = 0; !t; ) begin
        @(negedge i_mclk);
        t = arready;
        @(posedge i_mclk);
      end
      arvalid <= 1'b0;
      rready  <= 1'b1;
      for (t = 0; !t; ) begin
        @(negedge i_mclk);
        t = rvalid;
        @(posedge i_mclk);
      end
      rready <= 1'b0;
    end
  endtask
  task reset;
    i_resetn <= 1'b0;
    repeat (6) @(posedge i_mclk);
    i_resetn <= 1'b1;
    @(posedge i_mclk);
  endtask
  task settle;
    repeat (3) @(posedge i_mclk);
    while (busy) @(posedge i_mclk);
  endtask
  task pulse(input [7:0] m);
    env <= env | m;
    @(posedge i_mclk);
    env <= env & ~m;
  endtask
  // loads a random start address and notes the transfer it should launch
  task setup(input [7:0] f, input [7:0] c, input l, input p, input [8:0] n);
    begin
      xa = $random(seed);
      tag = $random(seed) & 8'h1f;
      wr(`QDW_A_FEAT, f);
      wr(`QDW_A_COUNT, c | (tag << 3));
      wr(`QDW_A_SECT, xa[7:0]);
      wr(`QDW_A_TLOW, xa[15:8]);
      wr(`QDW_A_THIGH, xa[23:16]);
      wr(`QDW_A_DHEAD, {1'b1, l, 2'b10, xa[27:24]});
      xq.push_back({p, l, n, xa});
    end
  endtask
  task summarize;
    if (xq.size() != 0) fails++;
    if (fails == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    fails++;
    summarize;
  end
  initial begin
    reset;
    rd(`QDW_A_STAT, `QDW_STAT_RST);
    rd(8'h34, 0, `QDW_RESP_SLVERR);
    wr(8'h34, 1, `QDW_RESP_SLVERR);
    // overlapped interrupt still disabled after reset
    wr(`QDW_A_CMD, `QDW_OP_QWRITE);
    settle;
    rd(`QDW_A_ERR, 8'h04);
    rd(`QDW_A_STAT, 8'h41);
    wr(`QDW_A_CTRL, 1);
    env <= 8'h04;
    tag = $random(seed) & 8'h1f;
    wr(`QDW_A_COUNT, tag << 3);
    wr(`QDW_A_CMD, `QDW_OP_QWRITE);
    settle;
    rd(`QDW_A_COUNT, (tag << 3) | 8'h04);
    rd(`QDW_A_STAT, 8'h50);
    rd(`QDW_A_EVT, 32'h1 << tag);
    wr(`QDW_A_CMD, `QDW_OP_QWRITE);
    settle;
    rd(`QDW_A_ERR, 8'h04);
    reset;
    wr(`QDW_A_CTRL, 1);
    for (i = 0; i < 2; i++) begin
      // completion drops the prepared flag, so mark data ready again
      wr(`QDW_A_EVT, 1);
      env <= i ? 8'h02 : 8'h04;
      if (i) setup(8'h00, 0, 1, 0, 9'h100);
      else setup(8'h07, 0, 0, 0, 9'h7);
      wr(`QDW_A_CMD, `QDW_OP_QWRITE);
      settle;
      rd(`QDW_A_ERR, 0);
      rd(`QDW_A_COUNT, (tag << 3) | 8'h03);
      rd(`QDW_A_STAT, i ? 8'h40 : 8'h50);
    end
    wr(`QDW_A_EVT, 1);
    env <= 8'h09;
    setup(8'h03, 0, 1, 0, 9'h3);
    wr(`QDW_A_CMD, `QDW_OP_QWRITE);
    settle;
    rd(`QDW_A_ERR, 8'h84);
    rd(`QDW_A_STAT, 8'h61);
    rd(`QDW_A_SECT, xa[7:0]);
    rd(`QDW_A_THIGH, xa[23:16]);
    env <= 8'h00;
    reset;
    pulse(8'h20);
    rd(`QDW_A_MEDIA, 2);
    wr(`QDW_A_CMD, `QDW_OP_MSTAT);
    settle;
    rd(`QDW_A_MEDIA, 0);
    pulse(8'h10);
    rd(`QDW_A_MEDIA, 1);
    setup(8'h00, 8'h02, 1, 1, 9'h2);
    wr(`QDW_A_COUNT, 2);
    wr(`QDW_A_CMD, `QDW_OP_WMULT);
    settle;
    rd(`QDW_A_ERR, 0);
    rd(`QDW_A_STAT, 8'h40);
    summarize;
  end
endmodule
bind qdw_core qdw_core_asserts i_qdw_core_asserts (.i_mclk(i_mclk), .i_resetn(i_resetn),
  .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wvalid(i_wvalid),
  .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
  .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rvalid(o_rvalid), .i_rready(i_rready),
  .o_xfer_start(o_xfer_start), .o_xfer_sectors(o_xfer_sectors),
  .i_sector_done(i_sector_done), .i_xfer_error(i_xfer_error),
  .o_queue_abort(o_queue_abort), .o_busy(o_busy));
